//--- hdl/cspd_pkg.sv
/*
  Constants and types for the skip, power-down and pointer control core.
  Assumes one 100 MHz clock and a decoder that hands over one operation per slot.
*/
package cspd_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int PC_W     = 14;   // Program counter
  localparam int PAGE_W   = 7;    // Page field
  localparam int ADDR_W   = 7;    // In-page address
  localparam int SP_W     = 3;    // Stack index
  localparam int STK_N    = 8;    // Return stack depth
  localparam int DP_W     = 10;   // RAM pointer
  localparam int Z_W      = 2;
  localparam int XY_W     = 4;
  localparam int A_W      = 4;
  localparam int D_W      = 3;
  localparam int E_W      = 8;
  localparam int TBL_W    = 10;   // Table word
  localparam int BUS_AW   = 4;
  localparam int BUS_DW   = 16;
  localparam int EV_W     = 3;    // Event bits

  // ****************************************
  // Cycle counts per slot
  // ****************************************
  localparam logic [1:0] CYC_ONE        = 2'h1;
  localparam logic [1:0] CYC_TABLE_CALL = 2'h3;
  localparam logic [1:0] CYC_RETURN     = 2'h2;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [BUS_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [BUS_AW-1:0] REG_STATUS = 4'h1;
  localparam logic [BUS_AW-1:0] REG_MASK   = 4'h2;
  localparam logic [BUS_AW-1:0] REG_PC     = 4'h3;
  localparam logic [BUS_AW-1:0] REG_CORE   = 4'h4;
  localparam logic [BUS_AW-1:0] REG_DP     = 4'h5;
  localparam logic [BUS_AW-1:0] REG_SP     = 4'h6;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_PORT9  = 0;  // Output port bit nine level
  localparam int CTRL_TSEL   = 1;  // Timer output pin select
  localparam int EV_EXT      = 0;  // External request flag was set
  localparam int EV_BACKUP   = 1;  // Back-up entered
  localparam int EV_WAKE     = 2;  // Back-up left
  localparam int CFG_WAVE    = 2;  // Active waveform select in config
  localparam int IEN_EXT     = 0;  // External enable in irq enable reg
  localparam logic [SP_W-1:0] SP_RST = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_A, OP_LOAD_B, OP_LOAD_D, OP_LOAD_E, OP_LXY, OP_LZ, OP_INY,
    OP_BRANCH, OP_BRANCH_LONG, OP_CALL, OP_TABLE_CALL, OP_RETURN, OP_RETURN_SKIP,
    OP_SKIP_TEST, OP_EXT_SKIP, OP_IRQ_MASK, OP_IRQ_UNMASK, OP_PD_ARM, OP_PD_ENTER,
    OP_LOAD_IEN, OP_LOAD_XCFG
  } cspd_op_t;

  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_BACKUP} cspd_state_t;
endpackage

//--- hdl/cspd_core.sv
/*
  Pipeline control of a small 4-bit core: skip nullify, power-down entry,
  program counter, return stack, data pointer and working registers.
  Assumes a same-clock decoder driving one operation per accepted slot, and
  asynchronous external interrupt and wakeup pins.
*/
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module cspd_core (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          ins_valid,
  input  wire cspd_pkg::cspd_op_t            ins_op,
  input  wire logic [cspd_pkg::PC_W-1:0]     ins_imm,
  input  wire logic                          skip_cond,
  input  wire logic [cspd_pkg::TBL_W-1:0]    tbl_data,
  input  wire logic                          ext_irq_pin,
  input  wire logic                          wake_pin,
  input  wire logic                          timer_wave,
  input  wire logic [cspd_pkg::BUS_AW-1:0]   bus_addr,
  input  wire logic [cspd_pkg::BUS_DW-1:0]   bus_wdata,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_rd,
  output logic [cspd_pkg::BUS_DW-1:0]        bus_rdata,
  output logic                               ins_ready,
  output logic [cspd_pkg::PC_W-1:0]          fetch_pc,
  output logic                               nullified,
  output logic                               ram_backup,
  output logic [cspd_pkg::DP_W-1:0]          ram_pointer,
  output logic                               ext_irq_take,
  output logic                               irq,
  output logic                               timer_out_pin,
  output logic                               output_port_bit_nine
);
  // ****************************************
  // Helpers
  // ****************************************
  // Slot length of an operation when it really executes
  function automatic logic [1:0] cycles_of(input cspd_pkg::cspd_op_t op);
    unique case (op)
      cspd_pkg::OP_TABLE_CALL:  cycles_of = cspd_pkg::CYC_TABLE_CALL;
      cspd_pkg::OP_RETURN:      cycles_of = cspd_pkg::CYC_RETURN;
      cspd_pkg::OP_RETURN_SKIP: cycles_of = cspd_pkg::CYC_RETURN;
      default:                  cycles_of = cspd_pkg::CYC_ONE;
    endcase
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  cspd_pkg::cspd_state_t              state_q, state_d;   // Slot sequencer
  logic [1:0]                         cnt_q;              // Extra cycles left
  logic [cspd_pkg::PC_W-1:0]          pc_q;               // Program counter
  logic [cspd_pkg::PC_W-1:0]          pc_inc;             // Return address
  logic [cspd_pkg::PC_W-1:0]          stack_q [cspd_pkg::STK_N]; // Return stack
  logic [cspd_pkg::SP_W-1:0]          sp_q;               // Stack index
  logic [cspd_pkg::A_W-1:0]           a_q, b_q;           // Accumulator and B
  logic [cspd_pkg::D_W-1:0]           d_q;                // D register
  logic [cspd_pkg::E_W-1:0]           e_q;                // E register
  logic [cspd_pkg::XY_W-1:0]          x_q, y_q;           // Pointer halves
  logic [cspd_pkg::Z_W-1:0]           z_q;                // Pointer bank
  logic [3:0]                         ien_q, xcfg_q;      // Irq enable, ext config
  logic                               skip_q;             // Next slot nullified
  logic                               arm_q;              // Power-down armed
  logic                               inte_q;             // Interrupt enable flag
  logic                               ext_flag_q;         // External request flag
  logic                               ext_m1_q, ext_s_q;  // Pin synchroniser
  logic                               wk_m1_q, wk_s_q;    // Wakeup synchroniser
  logic                               eff_q;              // Last effective level
  logic                               eff_lvl, ext_set;
  logic [1:0]                         ctrl_q;             // Port bit nine, timer select
  logic [cspd_pkg::EV_W-1:0]          status_q, mask_q, ev;
  logic                               take, exec, last_x, enter;
  logic                               tbl_q;              // Extra cycles are a table call

  // Slot taken; it executes unless a skip nullifies it
  assign take    = ins_valid & (state_q == cspd_pkg::ST_RUN);
  assign exec    = take & ~skip_q;
  assign last_x  = (state_q == cspd_pkg::ST_EXTRA) & (cnt_q == 2'h1);
  assign pc_inc  = pc_q + 14'h0001;
  assign enter   = exec & (ins_op == cspd_pkg::OP_PD_ENTER) & arm_q;

  // ****************************************
  // Slot sequencer
  // ****************************************
  // Next state of the slot sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cspd_pkg::ST_RUN: begin
        if (enter) begin
          state_d = cspd_pkg::ST_BACKUP;
        end else if (exec && cycles_of(ins_op) != cspd_pkg::CYC_ONE) begin
          state_d = cspd_pkg::ST_EXTRA;
        end
      end
      cspd_pkg::ST_EXTRA: begin
        if (cnt_q == 2'h1) begin
          state_d = cspd_pkg::ST_RUN;
        end
      end
      cspd_pkg::ST_BACKUP: begin
        // Clock kept alive here; only wakeup leaves
        if (wk_s_q) begin
          state_d = cspd_pkg::ST_RUN;
        end
      end
      default: state_d = cspd_pkg::ST_RUN;
    endcase
  end

  // State, extra-cycle counter and ready
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= cspd_pkg::ST_RUN;
      cnt_q     <= 2'h0;
      ins_ready <= 1'b1;
    end else begin
      state_q   <= state_d;
      ins_ready <= (state_d == cspd_pkg::ST_RUN);
      if (exec) begin
        cnt_q <= cycles_of(ins_op) - 2'h1;
      end else if (state_q == cspd_pkg::ST_EXTRA) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  // ****************************************
  // Skip and power-down flags
  // ****************************************
  // Skip set by tests and by return-skip, consumed by the next slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_q    <= 1'b0;
      nullified <= 1'b0;
    end else begin
      nullified <= take & skip_q;
      if (exec) begin
        skip_q <= ((ins_op == cspd_pkg::OP_SKIP_TEST) & skip_cond)
                | ((ins_op == cspd_pkg::OP_EXT_SKIP) & ext_flag_q)
                | (ins_op == cspd_pkg::OP_RETURN_SKIP);
      end else if (take) begin
        skip_q <= 1'b0;
      end
    end
  end

  // Arm lasts exactly one following slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      arm_q      <= 1'b0;
      ram_backup <= 1'b0;
      inte_q     <= 1'b0;
    end else begin
      if (take) begin
        arm_q <= exec & (ins_op == cspd_pkg::OP_PD_ARM);
      end
      ram_backup <= (state_d == cspd_pkg::ST_BACKUP);
      if (exec && ins_op == cspd_pkg::OP_IRQ_MASK) begin
        inte_q <= 1'b0;
      end else if (exec && ins_op == cspd_pkg::OP_IRQ_UNMASK) begin
        inte_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Program counter and return stack
  // ****************************************
  // Program counter and stack index
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_q <= 14'h0000;
      sp_q <= cspd_pkg::SP_RST;
    end else if (exec) begin
      unique case (ins_op)
        cspd_pkg::OP_BRANCH:      pc_q <= {pc_q[13:7], ins_imm[6:0]};
        cspd_pkg::OP_BRANCH_LONG: pc_q <= ins_imm;
        cspd_pkg::OP_CALL: begin
          pc_q <= ins_imm;
          sp_q <= sp_q + 3'h1;
        end
        cspd_pkg::OP_TABLE_CALL: begin
          pc_q <= {ins_imm[13:7], d_q, a_q};
          sp_q <= sp_q + 3'h1;
        end
        cspd_pkg::OP_RETURN, cspd_pkg::OP_RETURN_SKIP: begin
          pc_q <= stack_q[sp_q];
          sp_q <= sp_q - 3'h1;
        end
        default: pc_q <= pc_inc;
      endcase
    end else if (take) begin
      pc_q <= pc_inc;
    end else if (last_x && tbl_q) begin
      pc_q <= stack_q[sp_q];
      sp_q <= sp_q - 3'h1;
    end
  end

  // Tracks whether the pending extra cycles belong to a table call
  always_ff @(posedge mclk) begin
    if (rst) begin
      tbl_q <= 1'b0;
    end else if (exec) begin
      tbl_q <= (ins_op == cspd_pkg::OP_TABLE_CALL);
    end else if (last_x) begin
      tbl_q <= 1'b0;
    end
  end

  // Stack storage; no reset, contents undefined until pushed
  always_ff @(posedge mclk) begin
    if (exec && (ins_op == cspd_pkg::OP_CALL || ins_op == cspd_pkg::OP_TABLE_CALL)) begin
      stack_q[sp_q + 3'h1] <= pc_inc;
    end
  end

  // Fetch address follows the counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_pc <= 14'h0000;
    end else begin
      fetch_pc <= pc_q;
    end
  end

  // ****************************************
  // Working registers and data pointer
  // ****************************************
  // A, B, D, E loads
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_q <= 4'h0;
      b_q <= 4'h0;
      d_q <= 3'h0;
      e_q <= 8'h00;
    end else if (exec) begin
      unique case (ins_op)
        cspd_pkg::OP_LOAD_A: a_q <= ins_imm[3:0];
        cspd_pkg::OP_LOAD_B: b_q <= ins_imm[3:0];
        cspd_pkg::OP_LOAD_D: d_q <= ins_imm[2:0];
        cspd_pkg::OP_LOAD_E: e_q <= ins_imm[7:0];
        default: ;
      endcase
    end else if (last_x && tbl_q) begin
      // Low eight bits of the table word land in B and A at the end of the call
      b_q <= tbl_data[7:4];
      a_q <= tbl_data[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      x_q <= 4'h0;
      y_q <= 4'h0;
      z_q <= 2'h0;
    end else if (exec) begin
      unique case (ins_op)
        cspd_pkg::OP_LXY: begin
          x_q <= ins_imm[7:4];
          y_q <= ins_imm[3:0];
        end
        cspd_pkg::OP_LZ:  z_q <= ins_imm[1:0];
        cspd_pkg::OP_INY: y_q <= y_q + 4'h1;
        default: ;
      endcase
    end
  end

  // Pointer drives the RAM address
  always_ff @(posedge mclk) begin
    if (rst) begin
      ram_pointer <= 10'h000;
    end else begin
      ram_pointer <= {z_q, x_q, y_q};
    end
  end

  // ****************************************
  // External interrupt
  // ****************************************
  // Two-stage synchronisers for the pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_m1_q <= 1'b0;
      ext_s_q  <= 1'b0;
      wk_m1_q  <= 1'b0;
      wk_s_q   <= 1'b0;
    end else begin
      ext_m1_q <= ext_irq_pin;
      ext_s_q  <= ext_m1_q;
      wk_m1_q  <= wake_pin;
      wk_s_q   <= wk_m1_q;
    end
  end

  // Select inverts the pin, so a select change can look like an edge
  assign eff_lvl = xcfg_q[cspd_pkg::CFG_WAVE] ? ext_s_q : ~ext_s_q;
  assign ext_set = eff_lvl & ~eff_q & ~ram_backup;

  // Config loads from A; flag set wins over its clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ien_q      <= 4'h0;
      xcfg_q     <= 4'h0;
      eff_q      <= 1'b1;
      ext_flag_q <= 1'b0;
    end else begin
      eff_q <= eff_lvl;
      if (exec && ins_op == cspd_pkg::OP_LOAD_IEN) begin
        ien_q <= a_q;
      end
      if (exec && ins_op == cspd_pkg::OP_LOAD_XCFG) begin
        xcfg_q <= a_q;
      end
      if (ext_set) begin
        ext_flag_q <= 1'b1;
      end else if (exec && ins_op == cspd_pkg::OP_EXT_SKIP) begin
        ext_flag_q <= 1'b0;
      end
    end
  end

  // Request offered to the core only when all enables agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_irq_take <= 1'b0;
    end else begin
      ext_irq_take <= ext_flag_q & ien_q[cspd_pkg::IEN_EXT] & inte_q;
    end
  end

  // ****************************************
  // Register port and events
  // ****************************************
  assign ev[cspd_pkg::EV_EXT]    = ext_set;
  assign ev[cspd_pkg::EV_BACKUP] = enter;
  assign ev[cspd_pkg::EV_WAKE]   = (state_q == cspd_pkg::ST_BACKUP) & wk_s_q;

  // Control, sticky status and mask; event beats write-one-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q   <= 2'h0;
      status_q <= 3'h0;
      mask_q   <= 3'h0;
    end else begin
      if (bus_wr && bus_addr == cspd_pkg::REG_CTRL) begin
        ctrl_q <= bus_wdata[1:0];
      end
      if (bus_wr && bus_addr == cspd_pkg::REG_MASK) begin
        mask_q <= bus_wdata[2:0];
      end
      if (bus_wr && bus_addr == cspd_pkg::REG_STATUS) begin
        status_q <= (status_q & ~bus_wdata[2:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      unique case (bus_addr)
        cspd_pkg::REG_CTRL:   bus_rdata <= {14'h0000, ctrl_q};
        cspd_pkg::REG_STATUS: bus_rdata <= {13'h0000, status_q};
        cspd_pkg::REG_MASK:   bus_rdata <= {13'h0000, mask_q};
        cspd_pkg::REG_PC:     bus_rdata <= {2'h0, pc_q};
        cspd_pkg::REG_CORE:   bus_rdata <= {e_q, b_q, a_q};
        cspd_pkg::REG_DP:     bus_rdata <= {ext_s_q, ram_backup, ext_flag_q, d_q, z_q, x_q, y_q};
        cspd_pkg::REG_SP:     bus_rdata <= {skip_q, arm_q, inte_q, 10'h000, sp_q};
        default:              bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // Interrupt and pin outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq                  <= 1'b0;
      timer_out_pin        <= 1'b0;
      output_port_bit_nine <= 1'b0;
    end else begin
      irq           <= |(status_q & mask_q);
      timer_out_pin <= ctrl_q[cspd_pkg::CTRL_TSEL] & timer_wave;
      // port bit independent of timer select
      output_port_bit_nine <= ctrl_q[cspd_pkg::CTRL_PORT9];
    end
  end
endmodule

//--- sim/cspd_core_checker.sv
/* Checker for the skip, power-down and pointer control core.
   Assumes it is bound to cspd_core and sees only its ports. */
`timescale 1ns/10ps
module cspd_core_checker (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               ins_valid,
  input wire cspd_pkg::cspd_op_t ins_op,
  input wire logic [13:0]        ins_imm,
  input wire logic               skip_cond,
  input wire logic [9:0]         tbl_data,
  input wire logic               ext_irq_pin,
  input wire logic               wake_pin,
  input wire logic               timer_wave,
  input wire logic [3:0]         bus_addr,
  input wire logic [15:0]        bus_wdata,
  input wire logic               bus_wr,
  input wire logic               bus_rd,
  input wire logic [15:0]        bus_rdata,
  input wire logic               ins_ready,
  input wire logic [13:0]        fetch_pc,
  input wire logic               nullified,
  input wire logic               ram_backup,
  input wire logic [9:0]         ram_pointer,
  input wire logic               ext_irq_take,
  input wire logic               irq,
  input wire logic               timer_out_pin,
  input wire logic               output_port_bit_nine
);
  // ****************************************
  // Slot tracking
  // ****************************************
  logic tk;       // Slot accepted at this edge
  logic skip_q;   // Next slot is known to be nullified
  logic unsure_q; // Flag test outcome hidden, so next slot is not judged
  logic arm_w;    // Plain arm slot taken
  logic ent_w;    // Plain enter slot taken
  assign tk = ins_valid & ins_ready;
  assign arm_w = tk && !skip_q && ins_op == cspd_pkg::OP_PD_ARM;
  assign ent_w = tk && !skip_q && ins_op == cspd_pkg::OP_PD_ENTER;
  // Skip state follows taken slots only
  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_q   <= 1'b0;
      unsure_q <= 1'b0;
    end else if (tk) begin
      skip_q   <= !skip_q && ((ins_op == cspd_pkg::OP_SKIP_TEST && skip_cond)
                  || ins_op == cspd_pkg::OP_RETURN_SKIP);
      unsure_q <= !skip_q && ins_op == cspd_pkg::OP_EXT_SKIP;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_slot(cspd_pkg::cspd_op_t op);
    tk && !skip_q && !unsure_q && ins_op == op;
  endsequence
  sequence s_ctrl_write;
    bus_wr && bus_addr == cspd_pkg::REG_CTRL ##1 !bus_wr;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_table_call_stall: assert property (
    s_slot(cspd_pkg::OP_TABLE_CALL) |=> !ins_ready [*2] ##1 ins_ready)
    else $error("table call stall length wrong");
  a_return_stall: assert property (
    (s_slot(cspd_pkg::OP_RETURN) or s_slot(cspd_pkg::OP_RETURN_SKIP)) |=> !ins_ready ##1 ins_ready)
    else $error("return stall length wrong");
  a_skip_one_slot: assert property (
    tk && skip_q |=> ins_ready && nullified)
    else $error("skipped slot not nullified in one cycle");
  a_plain_not_null: assert property (
    tk && !skip_q && !unsure_q |=> !nullified)
    else $error("plain slot flagged as nullified");
  a_arm_enter_backup: assert property (
    s_slot(cspd_pkg::OP_PD_ARM) ##1 s_slot(cspd_pkg::OP_PD_ENTER) |=> ram_backup)
    else $error("arm then enter did not enter back-up");
  a_backup_needs_arm: assert property (
    $rose(ram_backup) |-> $past(ent_w) && $past(arm_w, 2))
    else $error("back-up entered without arm then enter");
  a_rdata_idle_zero: assert property (
    !$past(bus_rd) |-> bus_rdata == 16'h0)
    else $error("read data not zero outside read answer");
  a_port_nine_write: assert property (
    s_ctrl_write |=> output_port_bit_nine == $past(bus_wdata[0], 2))
    else $error("port bit nine does not follow control write");
  a_timer_pin_wave: assert property (
    timer_out_pin |-> $past(timer_wave))
    else $error("timer pin high without waveform");
endmodule
bind cspd_core cspd_core_checker u_chk (
  .mclk, .rst, .ins_valid, .ins_op, .ins_imm, .skip_cond, .tbl_data, .ext_irq_pin,
  .wake_pin, .timer_wave, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
  .ins_ready, .fetch_pc, .nullified, .ram_backup, .ram_pointer, .ext_irq_take, .irq,
  .timer_out_pin, .output_port_bit_nine
);

//--- sim/cspd_core_tb_top.sv
/* Testbench for the skip, power-down and pointer control core.
   Assumes cspd_pkg, the core and its checker are compiled before it. */
`timescale 1ns/10ps
module cspd_core_tb_top;
  logic               mclk = 1'b0, rst = 1'b1, ins_valid = 1'b0, skip_cond = 1'b0;
  logic               ext_irq_pin = 1'b0, wake_pin = 1'b0, timer_wave = 1'b0;
  logic               bus_wr = 1'b0, bus_rd = 1'b0, ins_ready, nullified, ram_backup;
  logic               ext_irq_take, irq, timer_out_pin, output_port_bit_nine;
  cspd_pkg::cspd_op_t ins_op = cspd_pkg::OP_NOP;
  cspd_pkg::cspd_op_t nops [5] = '{cspd_pkg::OP_LOAD_A, cspd_pkg::OP_TABLE_CALL,
                                   cspd_pkg::OP_RETURN, cspd_pkg::OP_RETURN_SKIP,
                                   cspd_pkg::OP_LOAD_A};
  logic [13:0]        ins_imm = 14'h0, fetch_pc, p, tg, ret [8];
  logic [9:0]         tbl_data = 10'h0, ram_pointer;
  logic [3:0]         bus_addr = 4'h0;
  logic [15:0]        bus_wdata = 16'h0, bus_rdata, d;
  logic [31:0]        seed, r;
  int                 fails = 0, n_compared = 0, i;
  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;
  cspd_core u_cspd_core (
    .mclk, .rst, .ins_valid, .ins_op, .ins_imm, .skip_cond, .tbl_data, .ext_irq_pin,
    .wake_pin, .timer_wave, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .ins_ready, .fetch_pc, .nullified, .ram_backup, .ram_pointer, .ext_irq_take, .irq,
    .timer_out_pin, .output_port_bit_nine
  );
  // Compare, count, report at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ins_ready !== 1'b1 && n < 30);
    if (ins_ready !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask
  // Valid stays up so back-to-back slots never lower it mid-step
  task automatic slot(input cspd_pkg::cspd_op_t op, input logic [13:0] imm,
                      input logic sk = 1'b0);
    ins_valid <= 1'b1;
    ins_op <= op;
    ins_imm <= imm;
    skip_cond <= sk;
    wait_ready();
  endtask
  task automatic idle(input int n);
    ins_valid <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Read into d; a zero mask only fetches
  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    @(posedge mclk);
    d = bus_rdata;
    if (m != 16'h0) chk(d & m, e);
  endtask
  function automatic logic [15:0] f_pc(input logic [13:0] pc, input logic [13:0] n);
    return {2'h0, pc + n};
  endfunction
  initial begin
    seed = 32'h59aedca7;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({10'h0, ins_ready, ram_backup, nullified, irq, timer_out_pin,
         output_port_bit_nine}, 16'h0020);
    rchk(cspd_pkg::REG_SP, 16'h0007, 16'h0007);
    // Random loads, pointer and long jumps
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      // 14-bit targets never leave program memory
      tg = 14'($random(seed));
      slot(cspd_pkg::OP_LOAD_A, 14'(r[3:0]));
      slot(cspd_pkg::OP_LOAD_B, 14'(r[7:4]));
      slot(cspd_pkg::OP_LOAD_E, 14'(r[15:8]));
      slot(cspd_pkg::OP_LOAD_D, 14'(r[18:16]));
      slot(cspd_pkg::OP_LXY, 14'(r[27:20]));
      slot(cspd_pkg::OP_LZ, 14'(r[29:28]));
      slot(cspd_pkg::OP_BRANCH_LONG, tg);
      idle(2);
      chk(16'(ram_pointer), 16'(r[29:20]));
      chk(16'(fetch_pc), f_pc(tg, 14'h0));
      rchk(cspd_pkg::REG_CORE, 16'hffff, r[15:0]);
      rchk(cspd_pkg::REG_DP, 16'h1fff, {3'h0, r[18:16], r[29:20]});
      rchk(cspd_pkg::REG_PC, 16'h3fff, f_pc(tg, 14'h0));
    end
    // Skip test, then a slot that must vanish in the first four passes and runs in the fifth
    for (i = 0; i < 5; i++) begin
      rchk(cspd_pkg::REG_PC, 16'h0, 16'h0);
      p = d[13:0];
      rchk(cspd_pkg::REG_CORE, 16'h0, 16'h0);
      slot(cspd_pkg::OP_SKIP_TEST, 14'h0, i < 4);
      slot(nops[i], 14'h5);
      idle(2);
      rchk(cspd_pkg::REG_CORE, 16'hffff, i < 4 ? d : {d[15:4], 4'h5});
      rchk(cspd_pkg::REG_PC, 16'h3fff, f_pc(p, 14'h2));
      rchk(cspd_pkg::REG_SP, 16'h0007, 16'h0007);
    end
    // Full table call
    tbl_data <= 10'($random(seed));
    rchk(cspd_pkg::REG_PC, 16'h0, 16'h0);
    p = d[13:0];
    slot(cspd_pkg::OP_TABLE_CALL, 14'h0a00);
    idle(4);
    rchk(cspd_pkg::REG_CORE, 16'h00ff, {8'h0, tbl_data[7:0]});
    rchk(cspd_pkg::REG_PC, 16'h3fff, f_pc(p, 14'h1));
    // Eight nested calls, then unwind
    rchk(cspd_pkg::REG_PC, 16'h0, 16'h0);
    ret[0] = d[13:0] + 14'h1;
    for (i = 0; i < 8; i++) begin
      tg = 14'($random(seed));
      slot(cspd_pkg::OP_CALL, tg);
      if (i < 7) ret[i + 1] = tg + 14'h1;
    end
    for (i = 7; i >= 0; i--) begin
      slot(i == 0 ? cspd_pkg::OP_RETURN_SKIP : cspd_pkg::OP_RETURN, 14'h0);
      if (i == 0) slot(cspd_pkg::OP_LOAD_A, 14'h9);
      idle(2);
      rchk(cspd_pkg::REG_PC, 16'h3fff, f_pc(ret[i], 14'(i == 0)));
    end
    // Waveform select change with the pin already high
    ext_irq_pin <= 1'b1;
    slot(cspd_pkg::OP_LOAD_A, 14'h0);
    slot(cspd_pkg::OP_LOAD_IEN, 14'h0);
    slot(cspd_pkg::OP_LOAD_A, 14'h4);
    slot(cspd_pkg::OP_LOAD_XCFG, 14'h0);
    slot(cspd_pkg::OP_NOP, 14'h0);
    slot(cspd_pkg::OP_EXT_SKIP, 14'h0);
    slot(cspd_pkg::OP_LOAD_A, 14'h3);
    idle(2);
    rchk(cspd_pkg::REG_STATUS, 16'h0001, 16'h0001);
    rchk(cspd_pkg::REG_CORE, 16'h000f, 16'h0004);
    rchk(cspd_pkg::REG_DP, 16'ha000, 16'h8000);
    chk(16'(ext_irq_take), 16'h0);
    // Enter alone, then arm and enter, then wake
    slot(cspd_pkg::OP_IRQ_MASK, 14'h0);
    slot(cspd_pkg::OP_PD_ENTER, 14'h0);
    idle(2);
    chk(16'(ram_backup), 16'h0);
    slot(cspd_pkg::OP_PD_ARM, 14'h0);
    slot(cspd_pkg::OP_PD_ENTER, 14'h0);
    idle(2);
    chk(16'(ram_backup), 16'h1);
    chk(16'(irq), 16'h0);
    wake_pin <= 1'b1;
    wait_ready();
    wake_pin <= 1'b0;
    @(posedge mclk);
    chk(16'(ram_backup), 16'h0);
    // Unmask the back-up event, then clear it
    wr(cspd_pkg::REG_MASK, 16'h0002);
    @(posedge mclk);
    chk(16'(irq), 16'h1);
    wr(cspd_pkg::REG_STATUS, 16'h0007);
    @(posedge mclk);
    chk(16'(irq), 16'h0);
    rchk(cspd_pkg::REG_STATUS, 16'h0007, 16'h0);
    // no timer reload is ever issued by this bench
    // Shared pins keep their port functions
    timer_wave <= 1'b1;
    wr(cspd_pkg::REG_CTRL, 16'h0003);
    repeat (2) @(posedge mclk);
    chk({14'h0, timer_out_pin, output_port_bit_nine}, 16'h3);
    timer_wave <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({14'h0, timer_out_pin, output_port_bit_nine}, 16'h1);
    // Read-only and unmapped places
    rchk(cspd_pkg::REG_PC, 16'h0, 16'h0);
    wr(cspd_pkg::REG_PC, ~d);
    rchk(cspd_pkg::REG_PC, 16'h3fff, {2'h0, d[13:0]});
    rchk(4'hf, 16'hffff, 16'h0);
    wrap_up();
  end
endmodule
